/* File: dv/xct_tester.sv */
// board tester model: drives the chain pins and keeps shared balls tied
`timescale 1ns/1ps
`include "xct_cfg.svh"
module xct_tester (
  input  wire logic        strap_i,
  input  wire logic [55:0] pat_i,
  input  wire logic [6:0]  sel_i,
  output logic      [26:0] c1_o,
  output logic      [25:0] c2_o,
  output logic      [55:0] c3_o,
  output logic      [55:0] c4_o,
  output logic      [24:0] c5_o,
  output logic      [23:0] c6_o,
  output logic      [23:0] c7_o
);
  // ============================================================
  // pattern to balls
  always_comb begin
    c1_o = sel_i[0] ? pat_i[26:0] : 27'h0;
    c2_o = sel_i[1] ? pat_i[25:0] : 26'h0;
    c3_o = sel_i[2] ? pat_i : 56'h0;
    c4_o = sel_i[3] ? pat_i : 56'h0;
    c5_o = sel_i[4] ? pat_i[24:0] : 25'h0;
    c6_o = sel_i[5] ? pat_i[23:0] : 24'h0;
    c7_o = sel_i[6] ? pat_i[23:0] : 24'h0;
    // the chain strap ball is also a chain 2 pin
    c2_o[`XCT_STRAP_C2_POS] = strap_i;
    // hub strobe pair always driven opposite
    c6_o[0] = ~c7_o[0];
  end
endmodule : xct_tester

/* File: dv/xct_top_tb_top.sv */
// self-checking testbench for the xor chain test mode block
`timescale 1ns/1ps
`include "xct_cfg.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module xct_top_tb_top;
  logic            clk_i = 1'b0;
  logic            reset_n_i = 1'b0;
  logic            tri_strap = 1'b0;
  logic            chn_strap = 1'b0;
  logic     [55:0] pat = 56'h0;
  logic     [6:0]  sel = 7'h0;
  logic     [6:0]  f_res = 7'h2a;
  logic     [6:0]  f_oe = 7'h51;
  logic            f_bi = 1'b0;
  wire logic [26:0] c1;
  wire logic [25:0] c2;
  wire logic [55:0] c3, c4;
  wire logic [24:0] c5;
  wire logic [23:0] c6, c7;
  wire logic [6:0]  res, oe_n;
  wire logic        bi_oe_n, cmode, tmode, rdy;
  int               n_fail = 0;
  int               checked = 0;

  always #50 clk_i = ~clk_i;

  xct_tester tester (.strap_i(chn_strap), .pat_i(pat), .sel_i(sel),
    .c1_o(c1), .c2_o(c2), .c3_o(c3), .c4_o(c4), .c5_o(c5), .c6_o(c6),
    .c7_o(c7));
  xct_top dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .tristate_strap_i(tri_strap), .chain_mode_strap_i(chn_strap),
    .chain1_pins_i(c1), .chain2_pins_i(c2), .chain3_pins_i(c3),
    .chain4_pins_i(c4), .chain5_pins_i(c5), .chain6_pins_i(c6),
    .chain7_pins_i(c7), .func_result_i(f_res), .func_oe_n_i(f_oe),
    .func_bidir_oe_n_i(f_bi), .chain_result_o(res),
    .chain_result_oe_n_o(oe_n), .bidir_oe_n_o(bi_oe_n),
    .chain_mode_o(cmode), .tristate_mode_o(tmode), .chain3_ready_o(rdy));

  // ============================================================
  // helpers
  function automatic logic par(input logic [55:0] v);
    return ~(^v);
  endfunction : par

  function automatic logic [6:0] ex();
    return {par(56'(c7)), par(56'(c6)), par(56'(c5)), par(c4), par(c3),
            par(56'(c2)), par(56'(c1))};
  endfunction : ex

  task automatic enter(input logic t, input logic c, input int low);
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    tri_strap <= t;
    chn_strap <= c;
    repeat (low) @(posedge clk_i);
    #10;
    `CHK({cmode, tmode}, 2'h0)
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #10;
  endtask : enter

  task automatic drive(input logic [55:0] v, input logic [6:0] s,
                       input logic [6:0] m);
    @(posedge clk_i);
    pat <= v;
    sel <= s;
    #10;
    `CHK(res & m, ex() & m)
  endtask : drive

  // ============================================================
  // scenarios
  task automatic t_plain();
    enter(1'b0, 1'b0, 3);
    @(posedge clk_i);
    f_res <= 7'h15;
    f_oe <= 7'h2e;
    f_bi <= 1'b1;
    #10;
    `CHK({cmode, tmode}, 2'h0)
    `CHK({res, oe_n, bi_oe_n}, {7'h15, 7'h2e, 1'h1})
  endtask : t_plain

  task automatic t_tri();
    enter(1'b1, 1'b0, 3);
    `CHK({tmode, oe_n, bi_oe_n}, 9'h1ff)
    @(posedge clk_i);
    tri_strap <= 1'b0;
    repeat (3) @(posedge clk_i);
    #10;
    `CHK({tmode, oe_n}, 8'hff)
    enter(1'b1, 1'b1, 3);
    `CHK({tmode, oe_n, bi_oe_n}, 9'h1ff)
  endtask : t_tri

  task automatic t_chain();
    enter(1'b0, 1'b1, 3);
    @(posedge clk_i);
    chn_strap <= 1'b0;
    #10;
    `CHK({cmode, bi_oe_n, oe_n, rdy}, {2'h3, 7'h04, 1'h0})
    drive(56'h0, 7'h7f, 7'h7b);
    `CHK(res & 7'h7b, 7'h5b)
    for (int i = 0; i < 24; i++) begin
      drive(56'h1 << i, 7'h7f, 7'h7b);
    end
    for (int i = 0; i <= 27; i++) begin
      drive(~({56{1'b1}} << i), 7'h01, 7'h01);
      `CHK(res[0], ~i[0])
    end
    @(posedge clk_i);
    chn_strap <= 1'b1;
    drive({56{1'b1}}, 7'h03, 7'h03);
    `CHK(res[1:0], 2'h2)
    `CHK(cmode, 1'b1)
  endtask : t_chain

  task automatic t_c3();
    int n;
    enter(1'b0, 1'b1, `XCT_C3_CYCLES);
    n = 0;
    while (rdy !== 1'b1 && n < `XCT_C3_CYCLES + 10) begin
      @(posedge clk_i);
      #10;
      n++;
    end
    #10;
    `CHK(n >= `XCT_C3_CYCLES - 5 && n <= `XCT_C3_CYCLES + 2, 1'b1)
    `CHK({rdy, oe_n}, 8'h80)
    drive(56'h5a_0f00_0000_0003, 7'h7f, 7'h7f);
  endtask : t_c3

  task summarize();
    if (n_fail == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  initial begin
    t_plain();
    t_tri();
    t_chain();
    t_c3();
    summarize();
  end

  initial begin
    #8000000;
    n_fail++;
    summarize();
  end
endmodule : xct_top_tb_top

/* File: src/xct_cfg.svh */
// constants for the xor chain test mode block
`ifndef XCT_CFG_SVH
`define XCT_CFG_SVH
// ============================================================
// chain layout
`define XCT_NUM_CHAINS     7
`define XCT_MAX_LEN        56
`define XCT_LEN_C1         27
`define XCT_LEN_C2         26
`define XCT_LEN_C3         56
`define XCT_LEN_C4         56
`define XCT_LEN_C5         25
`define XCT_LEN_C6         24
`define XCT_LEN_C7         24
`define XCT_CHAIN3_IDX     2
`define XCT_STRAP_C2_POS   17
// ============================================================
// chain 3 warm-up, in hub link clocks (clock runs at link rate)
`define XCT_C3_CYCLES      35000
`define XCT_CNT_W          16
// ============================================================
// reset values
`define XCT_MODE_RESET     1'b0
`endif

/* File: src/xct_chain.sv */
// one xor chain: parity of its pins with the first stage tied high
`timescale 1ns/1ps
module xct_chain #(
  parameter int LEN = 27
) (
  input  wire logic [LEN-1:0] pins_i,
  output wire logic           result_o
);
  logic [LEN:0] stage;

  assign stage[0] = 1'b1;
  genvar g;
  generate
    for (g = 0; g < LEN; g++) begin : g_stage
      assign stage[g+1] = stage[g] ^ pins_i[g];
    end
  endgenerate
  assign result_o = stage[LEN];
endmodule : xct_chain

/* File: src/xct_pkg.sv */
// types for the xor chain test mode block
package xct_pkg;
  // ============================================================
  // mode flags latched at reset release
  typedef struct packed {
    logic tristate;
    logic chain;
  } xct_mode_type;

  typedef enum logic [1:0] {
    XCT_IDLE,
    XCT_LOW_WAIT,
    XCT_HIGH_WAIT,
    XCT_READY
  } xct_c3_state_type;
endpackage : xct_pkg

/* File: src/xct_top.sv */
// xor chain board test and output tri-state mode logic
`timescale 1ns/1ps
`include "xct_cfg.svh"
module xct_top
  import xct_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    reset_n_i,
  input  wire logic                    tristate_strap_i,
  input  wire logic                    chain_mode_strap_i,
  input  wire logic [`XCT_LEN_C1-1:0]  chain1_pins_i,
  input  wire logic [`XCT_LEN_C2-1:0]  chain2_pins_i,
  input  wire logic [`XCT_LEN_C3-1:0]  chain3_pins_i,
  input  wire logic [`XCT_LEN_C4-1:0]  chain4_pins_i,
  input  wire logic [`XCT_LEN_C5-1:0]  chain5_pins_i,
  input  wire logic [`XCT_LEN_C6-1:0]  chain6_pins_i,
  input  wire logic [`XCT_LEN_C7-1:0]  chain7_pins_i,
  input  wire logic [`XCT_NUM_CHAINS-1:0] func_result_i,
  input  wire logic [`XCT_NUM_CHAINS-1:0] func_oe_n_i,
  input  wire logic                    func_bidir_oe_n_i,
  output logic [`XCT_NUM_CHAINS-1:0]   chain_result_o,
  output logic [`XCT_NUM_CHAINS-1:0]   chain_result_oe_n_o,
  output logic                         bidir_oe_n_o,
  output logic                         chain_mode_o,
  output logic                         tristate_mode_o,
  output logic                         chain3_ready_o
);
  // ============================================================
  // strap capture: sampled every clock while reset is low, and the
  // sample taken just before release becomes the mode
  logic strap_chain_q, strap_chain_d;
  logic strap_tri_q, strap_tri_d;
  xct_mode_type mode_q, mode_d;
  logic in_reset_q, in_reset_d;

  always_comb begin
    strap_chain_d = chain_mode_strap_i;
    strap_tri_d   = tristate_strap_i;
    in_reset_d    = 1'b0;
    mode_d        = mode_q;
    if (in_reset_q) begin
      mode_d.chain    = strap_chain_q;
      mode_d.tristate = strap_tri_q;
    end
  end

  // strap flops carry no reset so that they keep sampling while reset
  // is low; the last sample before release is what gets latched
  always_ff @(posedge clk_i) begin
    strap_chain_q <= strap_chain_d;
    strap_tri_q   <= strap_tri_d;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      in_reset_q      <= 1'b1;
      mode_q.chain    <= `XCT_MODE_RESET;
      mode_q.tristate <= `XCT_MODE_RESET;
    end else begin
      in_reset_q    <= in_reset_d;
      mode_q        <= mode_d;
    end
  end

  // the strap must still be high at release, so the first-edge sample
  // is taken after release from the last reset-phase value
  assign chain_mode_o    = mode_q.chain;
  assign tristate_mode_o = mode_q.tristate;

  // ============================================================
  // chain 3 warm-up counter, clocked by the hub link clock
  xct_c3_state_type c3_state_q, c3_state_d;
  logic [`XCT_CNT_W-1:0] c3_cnt_q, c3_cnt_d;

  always_comb begin
    c3_state_d   = c3_state_q;
    c3_cnt_d     = c3_cnt_q;
    case (c3_state_q)
      XCT_IDLE: begin
        c3_cnt_d     = `XCT_CNT_W'(1);
        if (chain_mode_strap_i)
          c3_state_d = XCT_LOW_WAIT;
      end
      XCT_LOW_WAIT: begin
        // entered from XCT_IDLE whenever the chain strap is high, except on the clock the warm-up arms; goes back to idle next clock
        c3_state_d = XCT_IDLE;
      end
      XCT_HIGH_WAIT: begin
        if (!chain_mode_strap_i) begin
          c3_state_d = XCT_IDLE;
        end else if (c3_cnt_q >= `XCT_CNT_W'(`XCT_C3_CYCLES)) begin
          c3_state_d = XCT_READY;
        end else begin
          c3_cnt_d = c3_cnt_q + `XCT_CNT_W'(1);
        end
      end
      XCT_READY: begin
        c3_state_d = XCT_READY;
      end
      default: c3_state_d = XCT_IDLE;
    endcase
  end

  // reset-low phase length is counted by its own counter below
  logic [`XCT_CNT_W-1:0] low_cnt_q;
  logic                  low_ok_q;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      c3_state_q   <= XCT_IDLE;
      c3_cnt_q     <= '0;
    end else if (low_ok_q && mode_q.chain == 1'b0 && in_reset_q) begin
      c3_state_q   <= XCT_HIGH_WAIT;
      c3_cnt_q     <= `XCT_CNT_W'(1);
    end else begin
      c3_state_q   <= c3_state_d;
      c3_cnt_q     <= c3_cnt_d;
    end
  end

  // counts clocks with reset low and strap high; the count cannot be
  // cleared by the reset it measures, so it uses a synchronous clear
  logic [`XCT_CNT_W-1:0] low_cnt_d;
  logic                  low_ok_d;

  always_comb begin
    low_cnt_d = low_cnt_q;
    low_ok_d  = low_ok_q;
    if (reset_n_i || !chain_mode_strap_i) begin
      if (!in_reset_q) begin
        low_cnt_d = '0;
        low_ok_d  = 1'b0;
      end
      if (!chain_mode_strap_i) begin
        low_cnt_d = '0;
        low_ok_d  = 1'b0;
      end
    end else if (low_cnt_q >= `XCT_CNT_W'(`XCT_C3_CYCLES - 1)) begin
      low_ok_d = 1'b1;
    end else begin
      low_cnt_d = low_cnt_q + `XCT_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    low_cnt_q <= low_cnt_d;
    low_ok_q  <= low_ok_d;
  end

  assign chain3_ready_o = (c3_state_q == XCT_READY) && mode_q.chain;

  // ============================================================
  // chains, combinational from pins to result
  logic [`XCT_NUM_CHAINS-1:0] raw;

  xct_chain #(.LEN(`XCT_LEN_C1)) u_c1 (
    .pins_i   (chain1_pins_i),
    .result_o (raw[0])
  );
  xct_chain #(.LEN(`XCT_LEN_C2)) u_c2 (
    .pins_i   (chain2_pins_i),
    .result_o (raw[1])
  );
  xct_chain #(.LEN(`XCT_LEN_C3)) u_c3 (
    .pins_i   (chain3_pins_i),
    .result_o (raw[2])
  );
  xct_chain #(.LEN(`XCT_LEN_C4)) u_c4 (
    .pins_i   (chain4_pins_i),
    .result_o (raw[3])
  );
  xct_chain #(.LEN(`XCT_LEN_C5)) u_c5 (
    .pins_i   (chain5_pins_i),
    .result_o (raw[4])
  );
  xct_chain #(.LEN(`XCT_LEN_C6)) u_c6 (
    .pins_i   (chain6_pins_i),
    .result_o (raw[5])
  );
  xct_chain #(.LEN(`XCT_LEN_C7)) u_c7 (
    .pins_i   (chain7_pins_i),
    .result_o (raw[6])
  );

  // ============================================================
  // output muxing: chain results bypass the clock entirely
  function automatic logic chain_live(input int idx, input logic rdy);
    chain_live = (idx == `XCT_CHAIN3_IDX) ? rdy : 1'b1;
  endfunction : chain_live

  genvar k;
  generate
    for (k = 0; k < `XCT_NUM_CHAINS; k++) begin : g_out
      always_comb begin
        if (mode_q.tristate) begin
          chain_result_o[k]      = 1'b0;
          chain_result_oe_n_o[k] = 1'b1;
        end else if (mode_q.chain && chain_live(k, chain3_ready_o)) begin
          chain_result_o[k]      = raw[k];
          chain_result_oe_n_o[k] = 1'b0;
        end else if (mode_q.chain) begin
          chain_result_o[k]      = 1'b0;
          chain_result_oe_n_o[k] = 1'b1;
        end else begin
          chain_result_o[k]      = func_result_i[k];
          chain_result_oe_n_o[k] = func_oe_n_i[k];
        end
      end
    end
  endgenerate

  assign bidir_oe_n_o = (mode_q.chain || mode_q.tristate) ? 1'b1
                        : func_bidir_oe_n_i;

  // ============================================================
  // checks
  sequence c3_armed_s;
    low_ok_q && in_reset_q && !mode_q.chain;
  endsequence

  sequence c3_counting_s;
    (c3_state_q == XCT_HIGH_WAIT) && chain_mode_strap_i;
  endsequence

  all_low_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (mode_q.chain && !mode_q.tristate && chain1_pins_i == '0)
      |-> chain_result_o[0] && !chain_result_oe_n_o[0])
    else $error("chain 1 all-low not high");
  parity_c2_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (mode_q.chain && !mode_q.tristate)
      |-> chain_result_o[1] == ~(^chain2_pins_i))
    else $error("chain 2 parity wrong");
  bidir_off_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    mode_q.chain |-> bidir_oe_n_o)
    else $error("bidir driven in chain mode");
  tri_off_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    mode_q.tristate |-> &chain_result_oe_n_o)
    else $error("output driven in tri-state mode");
  mode_hold_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !in_reset_q |=> $stable(mode_q))
    else $error("mode changed after release");
  strap_latch_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    in_reset_q |=> mode_q.chain == $past(strap_chain_q))
    else $error("chain strap not latched");
  c1_odd_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (mode_q.chain && !mode_q.tristate && &chain1_pins_i)
      |-> !chain_result_o[0])
    else $error("chain 1 all-high not low");
  c3_ready_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    chain3_ready_o |-> c3_cnt_q >= `XCT_CNT_W'(`XCT_C3_CYCLES))
    else $error("chain 3 ready too early");
  c3_arm_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    c3_armed_s |=> c3_state_q == XCT_HIGH_WAIT)
    else $error("chain 3 warm-up not started");
  c3_step_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    c3_counting_s ##0 (c3_cnt_q < `XCT_CNT_W'(`XCT_C3_CYCLES))
      |=> c3_cnt_q == $past(c3_cnt_q) + `XCT_CNT_W'(1))
    else $error("chain 3 warm-up count skipped");
  c3_gate_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (mode_q.chain && !mode_q.tristate && !chain3_ready_o)
      |-> chain_result_oe_n_o[`XCT_CHAIN3_IDX])
    else $error("chain 3 driven before warm-up");
  ready_hold_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    chain3_ready_o |=> chain3_ready_o)
    else $error("chain 3 ready dropped");
  func_pass_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (!mode_q.chain && !mode_q.tristate)
      |-> {chain_result_o, chain_result_oe_n_o, bidir_oe_n_o}
          == {func_result_i, func_oe_n_i, func_bidir_oe_n_i})
    else $error("functional drive not passed through");
  parity_c1_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (mode_q.chain && !mode_q.tristate)
      |-> chain_result_o[0] == ~(^chain1_pins_i))
    else $error("chain 1 parity wrong");
  parity_c3_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (chain3_ready_o && !mode_q.tristate)
      |-> chain_result_o[2] == ~(^chain3_pins_i))
    else $error("chain 3 parity wrong");
  parity_c7_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (mode_q.chain && !mode_q.tristate)
      |-> chain_result_o[6] == ~(^chain7_pins_i))
    else $error("chain 7 parity wrong");
endmodule : xct_top
